/* File: design/oem_pkg.sv */
/*
  shared constants and types of the output and exposure mode command block.
  assumes one 10 MHz clock and byte-wide receive and transmit streams.
*/
// Contract
// [RULE1] output mode: code 0xc0, one byte, read answered
// [RULE2] output byte: 0 s8, 1 d8, 2 s10, 3 d10
// [RULE3] exposure mode: code 0xa0, one byte, flag cleared
// [RULE4] exposure byte: 0 free prog, 4/5/6 external trigger
// [RULE5] one-byte write updates store, no data frame
// [RULE6] exposure byte 0x02: free-run, edge controlled
// [RULE7] frame: start, descriptor, data, xor check, end
// [RULE8] all checks pass: ack 0x06, else nak 0x15
// [RULE9] unknown code acked, no update, no range check
package oem_pkg;

  // ----------------------------------------------------------------
  // framing bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] FRAME_START_BYTE = 8'h02;
  localparam logic [7:0] FRAME_END_BYTE   = 8'h03;
  localparam logic [7:0] ACK_BYTE         = 8'h06;
  localparam logic [7:0] NAK_BYTE         = 8'h15;

  // ----------------------------------------------------------------
  // descriptor layout and command codes
  // ----------------------------------------------------------------
  localparam int unsigned READ_FLAG_BIT  = 7;
  localparam logic [6:0]  PARAM_LEN      = 7'h01;
  localparam logic [7:0]  CODE_OUT_MODE  = 8'hc0;
  localparam logic [7:0]  CODE_EXP_MODE  = 8'ha0;
  localparam logic [2:0]  RESP_LAST_IDX  = 3'h6;

  // ----------------------------------------------------------------
  // parameter values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OUT_SINGLE_8  = 8'h00;
  localparam logic [7:0] OUT_DUAL_8    = 8'h01;
  localparam logic [7:0] OUT_SINGLE_10 = 8'h02;
  localparam logic [7:0] OUT_DUAL_10   = 8'h03;
  localparam logic [7:0] EXP_FREE_PROG = 8'h00;
  localparam logic [7:0] EXP_FREE_EDGE = 8'h02;
  localparam logic [7:0] EXP_TRIG_LVL  = 8'h04;
  localparam logic [7:0] EXP_TRIG_PROG = 8'h05;
  localparam logic [7:0] EXP_TRIG_EDGE = 8'h06;
  localparam logic [7:0] OUT_MODE_RST  = 8'h00;
  localparam logic [7:0] EXP_MODE_RST  = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned BYTE_TIMEOUT_MS  = 1000;
  localparam int unsigned SILENCE_MS       = 1500;
  localparam int unsigned BYTE_TIMEOUT_CYC = (CLK_HZ / 1000) * BYTE_TIMEOUT_MS;
  localparam int unsigned SILENCE_CYC      = (CLK_HZ / 1000) * SILENCE_MS;
  localparam int unsigned GAP_W            = 24;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OEM_S_IDLE, OEM_S_CODE, OEM_S_LEN, OEM_S_DATA,
    OEM_S_BCC, OEM_S_END, OEM_S_GARBAGE, OEM_S_TX
  } oem_state_t;

  typedef enum logic [1:0] {
    OEM_CTL_PROG, OEM_CTL_LEVEL, OEM_CTL_EDGE
  } oem_exp_ctl_t;

endpackage : oem_pkg

/* File: design/oem_mode_dec.sv */
/*
  decodes the stored output and exposure mode bytes into control levels.
  assumes the bytes come from registers in the same clock domain.
*/
`timescale 1ns/1ps
module oem_mode_dec (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic [7:0]           out_mode,
  input  wire logic [7:0]           exp_mode,
  output logic                      dual_tap_q,
  output logic                      ten_bit_q,
  output logic                      ext_trig_q,
  output oem_pkg::oem_exp_ctl_t     exp_ctl_q,
  output logic                      exp_unknown_q
);
  import oem_pkg::*;

  logic         dual_tap_d;
  logic         ten_bit_d;
  logic         ext_trig_d;
  oem_exp_ctl_t exp_ctl_d;
  logic         exp_unknown_d;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    dual_tap_d    = 1'b0;
    ten_bit_d     = 1'b0;
    ext_trig_d    = 1'b0;
    exp_ctl_d     = OEM_CTL_PROG;
    exp_unknown_d = 1'b0;
    case (out_mode)                                     // [RULE2]
      OUT_DUAL_8:    dual_tap_d = 1'b1;
      OUT_SINGLE_10: ten_bit_d = 1'b1;
      OUT_DUAL_10: begin
        dual_tap_d = 1'b1;
        ten_bit_d  = 1'b1;
      end
      default: ;
    endcase
    case (exp_mode)                                     // [RULE4]
      EXP_FREE_PROG: exp_ctl_d = OEM_CTL_PROG;
      EXP_FREE_EDGE: exp_ctl_d = OEM_CTL_EDGE;          // [RULE6]
      EXP_TRIG_LVL: begin
        ext_trig_d = 1'b1;
        exp_ctl_d  = OEM_CTL_LEVEL;
      end
      EXP_TRIG_PROG: ext_trig_d = 1'b1;
      EXP_TRIG_EDGE: begin
        ext_trig_d = 1'b1;
        exp_ctl_d  = OEM_CTL_EDGE;
      end
      default: exp_unknown_d = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dual_tap_q    <= 1'b0;
      ten_bit_q     <= 1'b0;
      ext_trig_q    <= 1'b0;
      exp_ctl_q     <= OEM_CTL_PROG;
      exp_unknown_q <= 1'b0;
    end else begin
      dual_tap_q    <= dual_tap_d;
      ten_bit_q     <= ten_bit_d;
      ext_trig_q    <= ext_trig_d;
      exp_ctl_q     <= exp_ctl_d;
      exp_unknown_q <= exp_unknown_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dec_cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  out_dual10_a: assert property (out_mode == OUT_DUAL_10 |=> dual_tap_q && ten_bit_q) // [RULE2]
    else $error("dual 10 bit mode not decoded");
  exp_trig_edge_a: assert property ( // [RULE4]
    exp_mode == EXP_TRIG_EDGE |=> ext_trig_q && exp_ctl_q == OEM_CTL_EDGE)
    else $error("external edge exposure mode not decoded");
  exp_free_edge_a: assert property ( // [RULE6]
    exp_mode == EXP_FREE_EDGE |=> !ext_trig_q && exp_ctl_q == OEM_CTL_EDGE)
    else $error("free-run edge exposure mode not decoded");

endmodule : oem_mode_dec

/* File: design/oem_cmd.sv */
/*
  command frame interpreter for the output mode and exposure mode settings.
  assumes received bytes are held on rx_valid until taken while rx_ready is high, and a
  transmitter takes reply bytes with a valid/ready handshake.
*/
`timescale 1ns/1ps
module oem_cmd #(
  parameter int unsigned BYTE_TO_CYC = oem_pkg::BYTE_TIMEOUT_CYC,
  parameter int unsigned SILENCE_CYC = oem_pkg::SILENCE_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic [7:0]           rx_data,
  input  wire logic                 rx_valid,
  output logic                      rx_ready,
  output logic [7:0]                tx_data,
  output logic                      tx_valid,
  input  wire logic                 tx_ready,
  output logic [7:0]                out_mode,
  output logic [7:0]                exp_mode,
  output logic                      dual_tap,
  output logic                      ten_bit,
  output logic                      ext_trig,
  output oem_pkg::oem_exp_ctl_t     exp_ctl,
  output logic                      exp_mode_unknown
);
  import oem_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_param_code(input logic [7:0] code);
    is_param_code = (code == CODE_OUT_MODE) || (code == CODE_EXP_MODE);
  endfunction : is_param_code

  function automatic logic [7:0] resp_byte(input logic [2:0] idx, input logic [7:0] code,
                                           input logic [7:0] val);
    case (idx)
      3'h1:    resp_byte = FRAME_START_BYTE;
      3'h2:    resp_byte = code;
      3'h3:    resp_byte = {1'b0, PARAM_LEN};
      3'h4:    resp_byte = val;
      3'h5:    resp_byte = code ^ {1'b0, PARAM_LEN} ^ val;
      3'h6:    resp_byte = FRAME_END_BYTE;
      default: resp_byte = 8'h00;
    endcase
  endfunction : resp_byte

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  oem_state_t       state_q, state_d;
  logic [GAP_W-1:0] gap_q, gap_d;
  logic [7:0]       code_q, code_d;
  logic             rd_q, rd_d;
  logic [6:0]       len_q, len_d;
  logic [6:0]       cnt_q, cnt_d;
  logic [7:0]       chk_q, chk_d;
  logic [7:0]       val_q, val_d;
  logic             bcc_ok_q, bcc_ok_d;
  logic             frame_q, frame_d;
  logic [2:0]       idx_q, idx_d;
  logic [7:0]       tx_data_q, tx_data_d;
  logic             tx_valid_q, tx_valid_d;
  logic             rx_ready_q, rx_ready_d;
  logic [7:0]       out_mode_q, out_mode_d;
  logic [7:0]       exp_mode_q, exp_mode_d;
  logic             accept;
  logic             byte_to;
  logic             end_good;

  assign accept   = rx_valid && rx_ready_q;
  assign byte_to  = gap_q >= GAP_W'(BYTE_TO_CYC);
  assign end_good = (rx_data == FRAME_END_BYTE) && bcc_ok_q;

  // ----------------------------------------------------------------
  // frame parser and reply sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    code_d     = code_q;
    rd_d       = rd_q;
    len_d      = len_q;
    cnt_d      = cnt_q;
    chk_d      = chk_q;
    val_d      = val_q;
    bcc_ok_d   = bcc_ok_q;
    frame_d    = frame_q;
    idx_d      = idx_q;
    tx_data_d  = tx_data_q;
    tx_valid_d = tx_valid_q;
    out_mode_d = out_mode_q;
    exp_mode_d = exp_mode_q;
    gap_d      = accept ? '0 : ((&gap_q) ? gap_q : gap_q + GAP_W'(1));
    case (state_q)
      OEM_S_IDLE: begin
        if (accept && rx_data == FRAME_START_BYTE) state_d = OEM_S_CODE; // [RULE7]
      end
      OEM_S_CODE, OEM_S_LEN, OEM_S_DATA, OEM_S_BCC, OEM_S_END: begin
        if (byte_to) begin
          state_d = OEM_S_GARBAGE;
        end else if (accept) begin
          case (state_q)
            OEM_S_CODE: begin
              code_d  = rx_data;
              chk_d   = rx_data;                          // [RULE7]
              state_d = OEM_S_LEN;
            end
            OEM_S_LEN: begin
              rd_d    = rx_data[READ_FLAG_BIT];
              len_d   = rx_data[6:0];
              cnt_d   = 7'h00;
              chk_d   = chk_q ^ rx_data;                  // [RULE7]
              state_d = (!rx_data[READ_FLAG_BIT] && rx_data[6:0] != 7'h00) ?
                        OEM_S_DATA : OEM_S_BCC;
            end
            OEM_S_DATA: begin
              if (cnt_q == 7'h00) val_d = rx_data;
              chk_d = chk_q ^ rx_data;                    // [RULE7]
              cnt_d = cnt_q + 7'h01;
              if (cnt_q + 7'h01 == len_q) state_d = OEM_S_BCC;
            end
            OEM_S_BCC: begin
              bcc_ok_d = (rx_data == chk_q);              // [RULE7]
              state_d  = OEM_S_END;
            end
            default: begin
              tx_data_d  = end_good ? ACK_BYTE : NAK_BYTE; // [RULE8]
              tx_valid_d = 1'b1;
              idx_d      = 3'h0;
              state_d    = OEM_S_TX;
              frame_d    = end_good && rd_q && is_param_code(code_q) && len_q == PARAM_LEN;
              val_d      = (code_q == CODE_OUT_MODE) ? out_mode_q : exp_mode_q; // [RULE1] [RULE3]
              if (end_good && !rd_q && len_q == PARAM_LEN) begin // [RULE5] [RULE9]
                if (code_q == CODE_OUT_MODE) out_mode_d = val_q;
                if (code_q == CODE_EXP_MODE) exp_mode_d = val_q;
              end
              if (!rd_q) val_d = val_q;
            end
          endcase
        end
      end
      OEM_S_GARBAGE: begin
        if (gap_q >= GAP_W'(SILENCE_CYC)) state_d = OEM_S_IDLE;
      end
      default: begin
        if (tx_valid_q && tx_ready) begin
          if (idx_q == (frame_q ? RESP_LAST_IDX : 3'h0)) begin // [RULE5]
            tx_valid_d = 1'b0;
            state_d    = OEM_S_IDLE;
          end else begin
            idx_d     = idx_q + 3'h1;
            tx_data_d = resp_byte(idx_q + 3'h1, code_q, val_q); // [RULE1] [RULE3]
          end
        end
      end
    endcase
    rx_ready_d = (state_d != OEM_S_TX);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q    <= OEM_S_IDLE;
      gap_q      <= '0;
      code_q     <= 8'h00;
      rd_q       <= 1'b0;
      len_q      <= 7'h00;
      cnt_q      <= 7'h00;
      chk_q      <= 8'h00;
      val_q      <= 8'h00;
      bcc_ok_q   <= 1'b0;
      frame_q    <= 1'b0;
      idx_q      <= 3'h0;
      tx_data_q  <= 8'h00;
      tx_valid_q <= 1'b0;
      rx_ready_q <= 1'b1;
      out_mode_q <= OUT_MODE_RST;
      exp_mode_q <= EXP_MODE_RST;
    end else begin
      state_q    <= state_d;
      gap_q      <= gap_d;
      code_q     <= code_d;
      rd_q       <= rd_d;
      len_q      <= len_d;
      cnt_q      <= cnt_d;
      chk_q      <= chk_d;
      val_q      <= val_d;
      bcc_ok_q   <= bcc_ok_d;
      frame_q    <= frame_d;
      idx_q      <= idx_d;
      tx_data_q  <= tx_data_d;
      tx_valid_q <= tx_valid_d;
      rx_ready_q <= rx_ready_d;
      out_mode_q <= out_mode_d;
      exp_mode_q <= exp_mode_d;
    end
  end

  assign rx_ready = rx_ready_q;
  assign tx_data  = tx_data_q;
  assign tx_valid = tx_valid_q;
  assign out_mode = out_mode_q;
  assign exp_mode = exp_mode_q;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  oem_mode_dec u_dec (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .out_mode      (out_mode_q),
    .exp_mode      (exp_mode_q),
    .dual_tap_q    (dual_tap),
    .ten_bit_q     (ten_bit),
    .ext_trig_q    (ext_trig),
    .exp_ctl_q     (exp_ctl),
    .exp_unknown_q (exp_mode_unknown)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cmd_cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic end_hit;
  assign end_hit = accept && state_q == OEM_S_END && !byte_to;

  sequence ack_taken_s;
    tx_valid_q && tx_ready && idx_q == 3'h0 && tx_data_q == ACK_BYTE;
  endsequence

  sequence read_head_s;
    tx_data_q == FRAME_START_BYTE && tx_valid_q;
  endsequence

  ack_good_a: assert property (end_hit && end_good |=> tx_valid_q && tx_data_q == ACK_BYTE) // [RULE8]
    else $error("good frame not acknowledged");
  nak_bad_a: assert property (end_hit && !end_good |=> tx_valid_q && tx_data_q == NAK_BYTE) // [RULE8]
    else $error("bad frame not refused");
  read_frame_a: assert property ( // [RULE7]
    ack_taken_s ##0 frame_q |=> read_head_s)
    else $error("reply frame does not open with start byte");
  read_code_a: assert property ( // [RULE1]
    tx_valid_q && tx_ready && frame_q && idx_q == 3'h1 |=> tx_data_q == code_q)
    else $error("reply code byte does not follow start byte");
  read_frame_descriptor_a: assert property ( // [RULE1]
    tx_valid_q && idx_q == 3'h3 |-> tx_data_q == 8'h01 && frame_q)
    else $error("reply descriptor not read flag clear, length one");
  write_out_a: assert property ( // [RULE5]
    end_hit && end_good && !rd_q && len_q == PARAM_LEN && code_q == CODE_OUT_MODE
    |=> out_mode_q == $past(val_q))
    else $error("output mode write not stored");
  write_exp_a: assert property ( // [RULE3]
    end_hit && end_good && !rd_q && len_q == PARAM_LEN && code_q == CODE_EXP_MODE
    |=> exp_mode_q == $past(val_q))
    else $error("exposure mode write not stored");
  write_no_frame_a: assert property ( // [RULE5]
    ack_taken_s ##0 !rd_q |=> !tx_valid_q ##1 !tx_valid_q)
    else $error("write answered with a data frame");
  unknown_keep_a: assert property ( // [RULE9]
    end_hit && !is_param_code(code_q) |=> $stable(out_mode_q) && $stable(exp_mode_q) && !frame_q)
    else $error("unknown code changed a setting");

endmodule : oem_cmd

/* File: testbench/oem_host_model.sv */
/*
  host side model: builds command frames and sends them byte by byte,
  takes reply bytes with an optional stall before each one.
  assumes one clock shared with the command block and rising-edge sampling.
*/
`timescale 1ns/1ps
module oem_host_model (
  input  wire logic       clk,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  import oem_pkg::*;

  logic [7:0] fb [0:7];
  int         fn;

  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end

  // ----------------------------------------------------------------
  // frame sending, each byte held until taken
  // ----------------------------------------------------------------
  task send_frame;
    int i;
    @(posedge clk);
    for (i = 0; i < fn; i++) begin
      rx_data  <= fb[i];
      rx_valid <= 1'b1;
      @(negedge clk);
      while (rx_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~fb[fn-1];
  endtask : send_frame

  // write frame; bcc_err spoils the check byte, end_b stands at the end
  task write_cmd(input logic [7:0] code, input logic [7:0] val,
                 input logic [7:0] bcc_err, input logic [7:0] end_b);
    fb[0] = FRAME_START_BYTE;
    fb[1] = code;
    fb[2] = {1'b0, PARAM_LEN};
    fb[3] = val;
    fb[4] = code ^ {1'b0, PARAM_LEN} ^ val ^ bcc_err;
    fb[5] = end_b;
    fn    = 6;
    send_frame();
  endtask : write_cmd

  // read frame: flag set, length one, no data bytes
  task read_cmd(input logic [7:0] code);
    fb[0] = FRAME_START_BYTE;
    fb[1] = code;
    fb[2] = {1'b1, PARAM_LEN};
    fb[3] = code ^ {1'b1, PARAM_LEN};
    fb[4] = FRAME_END_BYTE;
    fn    = 5;
    send_frame();
  endtask : read_cmd

  // ----------------------------------------------------------------
  // reply taking, called at a rising edge
  // ----------------------------------------------------------------
  task get_byte(input int stall, output logic [7:0] b);
    if (stall > 0) begin
      tx_ready <= 1'b0;
      repeat (stall) @(posedge clk);
    end
    tx_ready <= 1'b1;
    @(negedge clk);
    while (tx_valid !== 1'b1) @(negedge clk);
    b = tx_data;
    @(posedge clk);
  endtask : get_byte

endmodule : oem_host_model

/* File: testbench/output_exposure_mode_commands_test.sv */
/*
  self-checking bench of the mode command block: reset, then a table of
  writes and read-backs, bad frames, unknown codes and a held frame.
  assumes the host model file and the design package are compiled first.
*/
`timescale 1ns/1ps
module output_exposure_mode_commands_test;
  import oem_pkg::*;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] val;
    logic       dual;
    logic       ten;
    logic       trig;
    logic [1:0] ctl;
    logic       unk;
  } oem_row_t;

  logic               clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic [7:0]         rx_data;
  logic               rx_valid;
  logic               rx_ready;
  logic [7:0]         tx_data;
  logic               tx_valid;
  logic               tx_ready;
  logic [7:0]         out_mode;
  logic [7:0]         exp_mode;
  logic               dual_tap;
  logic               ten_bit;
  logic               ext_trig;
  oem_exp_ctl_t       exp_ctl;
  logic               exp_mode_unknown;
  int                 err_count = 0;
  int                 n_compared = 0;
  int                 cyc = 0;
  int                 i;
  oem_row_t           r;
  oem_row_t           rows [0:9] = '{
    '{8'hc0, 8'h00, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0},
    '{8'hc0, 8'h01, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0},
    '{8'hc0, 8'h02, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0},
    '{8'hc0, 8'h03, 1'b1, 1'b1, 1'b0, 2'h0, 1'b0},
    '{8'ha0, 8'h00, 1'b1, 1'b1, 1'b0, 2'h0, 1'b0},
    '{8'ha0, 8'h02, 1'b1, 1'b1, 1'b0, 2'h2, 1'b0},
    '{8'ha0, 8'h04, 1'b1, 1'b1, 1'b1, 2'h1, 1'b0},
    '{8'ha0, 8'h05, 1'b1, 1'b1, 1'b1, 2'h0, 1'b0},
    '{8'ha0, 8'h06, 1'b1, 1'b1, 1'b1, 2'h2, 1'b0},
    '{8'ha0, 8'h07, 1'b1, 1'b1, 1'b0, 2'h0, 1'b1}
  };

  always #50 clk = ~clk;

  oem_cmd #(.BYTE_TO_CYC(50), .SILENCE_CYC(80)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .out_mode(out_mode), .exp_mode(exp_mode), .dual_tap(dual_tap), .ten_bit(ten_bit),
    .ext_trig(ext_trig), .exp_ctl(exp_ctl), .exp_mode_unknown(exp_mode_unknown)
  );

  oem_host_model host_u (
    .clk(clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready)
  );

  // ----------------------------------------------------------------
  // compare and report tasks
  // ----------------------------------------------------------------
  task chk_byte(input string name, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask : chk_byte

  task chk_flag(input string name, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %b seen %b", name, e, g);
    end
  endtask : chk_flag

  task results;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // reply helpers
  // ----------------------------------------------------------------
  task take(input int stall, input logic [7:0] e);
    logic [7:0] b;
    host_u.get_byte(stall, b);
    chk_byte("tx_data", e, b);
  endtask : take

  task no_reply(input int n);
    repeat (n) begin
      @(negedge clk);
      chk_flag("tx_valid", 1'b0, tx_valid);
    end
  endtask : no_reply

  task read_reply(input logic [7:0] code, input logic [7:0] val, input int stall);
    take(stall, ACK_BYTE);
    take(0, FRAME_START_BYTE);
    take(1, code);
    take(0, 8'h01);
    take(2, val);
    take(0, code ^ 8'h01 ^ val);
    take(0, FRAME_END_BYTE);
  endtask : read_reply

  task check_read(input logic [7:0] code, input logic [7:0] val, input int stall);
    host_u.read_cmd(code);
    read_reply(code, val, stall);
  endtask : check_read

  task check_state(input oem_row_t s, input logic [7:0] om, input logic [7:0] em);
    chk_byte("out_mode", om, out_mode);
    chk_byte("exp_mode", em, exp_mode);
    chk_flag("dual_tap", s.dual, dual_tap);
    chk_flag("ten_bit", s.ten, ten_bit);
    chk_flag("ext_trig", s.trig, ext_trig);
    chk_byte("exp_ctl", {6'h00, s.ctl}, {6'h00, exp_ctl});
    chk_flag("exp_unknown", s.unk, exp_mode_unknown);
  endtask : check_state

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk_flag("rx_ready", 1'b1, rx_ready);
    check_state(rows[0], OUT_MODE_RST, EXP_MODE_RST);
    $display("test reset done");
    for (i = 0; i < 10; i++) begin
      r = rows[i];
      host_u.write_cmd(r.code, r.val, 8'h00, FRAME_END_BYTE);
      take(0, ACK_BYTE);
      no_reply(4);
      check_state(r, (r.code == CODE_OUT_MODE) ? r.val : 8'h03,
                  (r.code == CODE_EXP_MODE) ? r.val : 8'h00);
      check_read(r.code, r.val, i % 3);
    end
    $display("test table done");
    host_u.write_cmd(CODE_OUT_MODE, 8'h01, 8'h10, FRAME_END_BYTE);
    take(0, NAK_BYTE);
    no_reply(3);
    host_u.write_cmd(CODE_EXP_MODE, 8'h04, 8'h00, 8'h04);
    take(0, NAK_BYTE);
    no_reply(3);
    check_state(rows[9], 8'h03, 8'h07);
    $display("test bad frames done");
    host_u.write_cmd(8'h55, 8'h00, 8'h00, FRAME_END_BYTE);
    take(0, ACK_BYTE);
    no_reply(3);
    host_u.read_cmd(8'h55);
    take(0, ACK_BYTE);
    no_reply(6);
    check_state(rows[9], 8'h03, 8'h07);
    $display("test unknown code done");
    host_u.fb[0] = FRAME_START_BYTE;
    host_u.fb[1] = CODE_OUT_MODE;
    host_u.fn    = 2;
    host_u.send_frame();
    repeat (60) @(posedge clk);
    host_u.write_cmd(CODE_OUT_MODE, 8'h01, 8'h00, FRAME_END_BYTE);
    no_reply(8);
    check_state(rows[9], 8'h03, 8'h07);
    repeat (90) @(posedge clk);
    $display("test byte timeout done");
    host_u.write_cmd(CODE_OUT_MODE, 8'h00, 8'h00, FRAME_END_BYTE);
    fork
      host_u.read_cmd(CODE_OUT_MODE);
      take(5, ACK_BYTE);
      begin
        @(negedge clk);
        chk_flag("rx_ready", 1'b0, rx_ready);
      end
    join
    read_reply(CODE_OUT_MODE, 8'h00, 0);
    $display("test held frame done");
    results();
  end

endmodule : output_exposure_mode_commands_test
